// ===== panel_driver.sv
// panel driver end: reset filter, settings reload, blanking, sleep modes
// assumes link pins synchronous to clk_sys; host keeps its own waits
//
// Function
// R1: reset input is active low
// R2: awake: host waits 120 ms before supply off
// R3: dozing: supplies may drop at once
// R4: chip select free or tied low
// R5: reset beats chip select
// R6: host pulses reset after unsteady power-up
// R7: no abnormal image while asleep
// R8: ignore spikes under 5 us, reset past 9 us
// R9: spike rejection inside valid reset too
// R10: reload settings within 5 ms of release
// R11: blank during reset, then defaults
// R12: host waits 5 ms before commands
// R13: no leave-sleep before 120 ms
// R14: host times waits on free counter
`timescale 1ns/1ns
module panel_driver
    import rst_seq_pkg::*;
#(
    parameter int unsigned RELOAD_CYCLES = RELOAD_CYC,
    parameter int unsigned BLANK_CYCLES  = BLANK_CYC
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    // link
    panel_link_if.device    link,
    // status
    output logic            reset_active,
    output logic            display_on,
    output logic            awake,
    output logic            settings_loaded,
    output logic            cmd_accepted
);
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_BLANK  = 3'b001,
        ST_HOLD   = 3'b010,
        ST_RELOAD = 3'b011,
        ST_READY  = 3'b100
    } state_t;

    typedef struct packed {
        state_t           state;
        logic [7:0]       low_cnt;
        logic [7:0]       high_cnt;
        logic             filt_low;
        logic [CNT_W-1:0] timer;
        logic             awake;
        logic             display_on;
        logic             loaded;
        logic             cmd_ok;
    } drv_t;

    drv_t cur_reg;
    drv_t cur_next;
    logic powered;

    assign powered = link.io_supply_rail & link.analog_supply_rail;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        cur_next        = cur_reg;
        cur_next.cmd_ok = 1'b0;
        // reset line filter, low is a request  [R1]
        if (!link.hw_reset_line_n) begin
            cur_next.high_cnt = '0;
            if (cur_reg.low_cnt < 8'(ACCEPT_CYC)) begin
                cur_next.low_cnt = cur_reg.low_cnt + 8'h01;
            end
            if (cur_reg.low_cnt + 8'h01 >= 8'(ACCEPT_CYC)) begin
                cur_next.filt_low = 1'b1; // [R8]
            end
        end else begin
            if (cur_reg.filt_low) begin
                // short highs inside a reset are spikes too  [R9]
                if (cur_reg.high_cnt < 8'(SPIKE_CYC)) begin
                    cur_next.high_cnt = cur_reg.high_cnt + 8'h01;
                end else begin
                    cur_next.filt_low = 1'b0;
                    cur_next.low_cnt  = '0;
                end
            end else begin
                cur_next.low_cnt = '0; // short lows rejected  [R8]
            end
        end

        if (!powered) begin
            cur_next.state      = ST_IDLE;
            cur_next.awake      = 1'b0;
            cur_next.display_on = 1'b0;
            cur_next.loaded     = 1'b0;
        end else if (cur_next.filt_low) begin
            // reset wins over chip select and commands  [R5]
            cur_next.display_on = 1'b0; // [R11]
            cur_next.loaded     = 1'b0;
            if (cur_reg.state != ST_BLANK && cur_reg.state != ST_HOLD) begin
                cur_next.state = cur_reg.awake ? ST_BLANK : ST_HOLD;
                cur_next.timer = '0;
            end else if (cur_reg.state == ST_BLANK) begin
                if (cur_reg.timer >= CNT_W'(BLANK_CYCLES - 1)) begin
                    cur_next.state = ST_HOLD;
                    cur_next.awake = 1'b0; // [R11]
                end else begin
                    cur_next.timer = cur_reg.timer + 1'b1;
                end
            end else begin
                cur_next.awake = 1'b0;
            end
        end else begin
            case (cur_reg.state)
                ST_IDLE, ST_BLANK, ST_HOLD: begin
                    cur_next.state = ST_RELOAD;
                    cur_next.timer = '0;
                    cur_next.awake = 1'b0;
                end
                ST_RELOAD: begin
                    // reload stands in for the nonvolatile copy  [R10]
                    if (cur_reg.timer >= CNT_W'(RELOAD_CYCLES - 1)) begin
                        cur_next.state  = ST_READY;
                        cur_next.loaded = 1'b1;
                    end else begin
                        cur_next.timer = cur_reg.timer + 1'b1;
                    end
                end
                ST_READY: begin
                    if (link.cmd_valid && !link.chip_select_line_n) begin
                        cur_next.cmd_ok = 1'b1;
                        if (link.cmd_code == CMD_LEAVE_SLEEP) begin
                            cur_next.awake      = 1'b1;
                            cur_next.display_on = 1'b1;
                        end else if (link.cmd_code == CMD_ENTER_SLEEP) begin
                            cur_next.awake      = 1'b0;
                            cur_next.display_on = 1'b0; // [R7]
                        end
                    end
                end
                default: begin
                    cur_next.state = ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cur_reg <= '{state: ST_IDLE, low_cnt: '0, high_cnt: '0, filt_low: 1'b0, timer: '0,
                         awake: 1'b0, display_on: 1'b0, loaded: 1'b0, cmd_ok: 1'b0};
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign reset_active    = cur_reg.filt_low;
    assign display_on      = cur_reg.display_on; // [R7]
    assign awake           = cur_reg.awake;
    assign settings_loaded = cur_reg.loaded;
    assign cmd_accepted    = cur_reg.cmd_ok;
endmodule

// ===== rst_seq_pkg.sv
// shared constants for the panel reset and power sequencing ends
// assumes a single 10 MHz system clock on both ends
package rst_seq_pkg;
    localparam int unsigned CLK_HZ              = 10_000_000;
    localparam int unsigned SPIKE_REJECT_NS     = 5_000;
    localparam int unsigned RESET_ACCEPT_NS     = 9_000;
    localparam int unsigned RELOAD_MAX_US       = 5_000;
    localparam int unsigned BLANK_MAX_US        = 120_000;
    localparam int unsigned CMD_WAIT_US         = 5_000;
    localparam int unsigned WAKE_WAIT_US        = 120_000;
    localparam int unsigned SUPPLY_OFF_AWAKE_US = 120_000;
    localparam int unsigned SUPPLY_OFF_DOZE_US  = 0;
    localparam int unsigned RESET_PULSE_US      = 10;
    // least times round up, longest round down
    localparam int unsigned SPIKE_CYC   = (SPIKE_REJECT_NS * (CLK_HZ / 1_000_000)) / 1_000;
    localparam int unsigned ACCEPT_CYC  = ((RESET_ACCEPT_NS * (CLK_HZ / 1_000_000)) + 999) / 1_000;
    localparam int unsigned RELOAD_CYC  = RELOAD_MAX_US * (CLK_HZ / 1_000_000) / 2;
    localparam int unsigned BLANK_CYC   = BLANK_MAX_US * (CLK_HZ / 1_000_000) / 2;
    localparam int unsigned CMD_CYC     = CMD_WAIT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned WAKE_CYC    = WAKE_WAIT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned OFF_AWAKE_CYC = SUPPLY_OFF_AWAKE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned OFF_DOZE_CYC  = SUPPLY_OFF_DOZE_US * (CLK_HZ / 1_000_000) + 1;
    localparam int unsigned PULSE_CYC   = RESET_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CNT_W       = 24;
    localparam logic [1:0]  CMD_LEAVE_SLEEP = 2'h1;
    localparam logic [1:0]  CMD_ENTER_SLEEP = 2'h2;
    localparam logic [1:0]  CMD_OTHER       = 2'h3;
endpackage

// ===== panel_link_if.sv
// pins between host sequencer and panel driver
// assumes both ends on clk_sys
`timescale 1ns/1ns
interface panel_link_if;
    logic       hw_reset_line_n;
    logic       chip_select_line_n;
    logic       io_supply_rail;
    logic       analog_supply_rail;
    logic       cmd_valid;
    logic [1:0] cmd_code;
    modport host (
        output hw_reset_line_n, chip_select_line_n, io_supply_rail, analog_supply_rail, cmd_valid, cmd_code
    );
    modport device (
        input  hw_reset_line_n, chip_select_line_n, io_supply_rail, analog_supply_rail, cmd_valid, cmd_code
    );
endinterface

// ===== panel_host.sv
// host sequencer end: supplies, reset pulse, timed commands
// assumes one clk_sys; user asks for power up, wake, sleep, power down
`timescale 1ns/1ns
module panel_host
    import rst_seq_pkg::*;
#(
    parameter int unsigned CMD_CYCLES   = CMD_CYC,
    parameter int unsigned WAKE_CYCLES  = WAKE_CYC,
    parameter int unsigned OFF_CYCLES   = OFF_AWAKE_CYC,
    parameter int unsigned PULSE_CYCLES = PULSE_CYC
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    // user requests
    input  wire logic       req_power_up,
    input  wire logic       req_wake,
    input  wire logic       req_sleep,
    input  wire logic       req_power_down,
    // status
    output logic            busy,
    output logic            host_awake,
    // link
    panel_link_if.host      link
);
    typedef enum logic [2:0] {
        H_OFF   = 3'b000,
        H_RST   = 3'b001,
        H_WAIT  = 3'b010,
        H_READY = 3'b011,
        H_DOWN  = 3'b100
    } hstate_t;

    typedef struct packed {
        hstate_t          state;
        logic [CNT_W-1:0] free_cnt;
        logic [CNT_W-1:0] mark;
        logic             rst_n;
        logic             supply;
        logic             cmd_valid;
        logic [1:0]       cmd_code;
        logic             awake;
    } host_t;

    host_t h_reg;
    host_t h_next;
    logic [CNT_W-1:0] elapsed;

    // free-running time base  [R14]
    assign elapsed = h_reg.free_cnt - h_reg.mark;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        h_next           = h_reg;
        h_next.free_cnt  = h_reg.free_cnt + 1'b1;
        h_next.cmd_valid = 1'b0;
        case (h_reg.state)
            H_OFF: begin
                if (req_power_up) begin
                    h_next.supply = 1'b1;
                    h_next.rst_n  = 1'b0; // pulse after power-up  [R6]
                    h_next.mark   = h_reg.free_cnt;
                    h_next.state  = H_RST;
                end
            end
            H_RST: begin
                if (elapsed >= CNT_W'(PULSE_CYCLES)) begin
                    h_next.rst_n = 1'b1;
                    h_next.mark  = h_reg.free_cnt;
                    h_next.state = H_WAIT;
                end
            end
            H_WAIT: begin
                if (elapsed >= CNT_W'(CMD_CYCLES)) begin
                    h_next.state = H_READY; // [R12]
                end
            end
            H_READY: begin
                if (req_power_down) begin
                    h_next.rst_n = 1'b0;
                    h_next.mark  = h_reg.free_cnt;
                    h_next.state = H_DOWN;
                end else if (req_wake && !h_reg.awake && elapsed >= CNT_W'(WAKE_CYCLES)) begin
                    h_next.cmd_valid = 1'b1; // [R13]
                    h_next.cmd_code  = CMD_LEAVE_SLEEP;
                    h_next.awake     = 1'b1;
                end else if (req_sleep && h_reg.awake) begin
                    h_next.cmd_valid = 1'b1;
                    h_next.cmd_code  = CMD_ENTER_SLEEP;
                    h_next.awake     = 1'b0;
                end
            end
            H_DOWN: begin
                // awake panel needs its blanking time  [R2] [R3]
                if (!h_reg.awake || elapsed >= CNT_W'(OFF_CYCLES)) begin
                    h_next.supply = 1'b0;
                    h_next.awake  = 1'b0;
                    h_next.state  = H_OFF;
                end
            end
            default: begin
                h_next.state = H_OFF;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            h_reg <= '{state: H_OFF, free_cnt: '0, mark: '0, rst_n: 1'b0, supply: 1'b0,
                       cmd_valid: 1'b0, cmd_code: 2'h0, awake: 1'b0};
        end else begin
            h_reg <= h_next;
        end
    end

    assign link.hw_reset_line_n    = h_reg.rst_n;
    assign link.chip_select_line_n = 1'b0; // tied low  [R4]
    assign link.io_supply_rail     = h_reg.supply;
    assign link.analog_supply_rail = h_reg.supply;
    assign link.cmd_valid          = h_reg.cmd_valid;
    assign link.cmd_code           = h_reg.cmd_code;
    assign busy                    = (h_reg.state != H_READY);
    assign host_awake              = h_reg.awake;
endmodule

// ===== panel_link_properties.sv
// concurrent checks on the host to driver link pins
// assumes instantiation in tb_top beside the joining interface
`timescale 1ns/1ns
module panel_link_properties
    import rst_seq_pkg::*;
#(
    parameter int unsigned CMD_CYCLES  = CMD_CYC,
    parameter int unsigned WAKE_CYCLES = WAKE_CYC,
    parameter int unsigned OFF_CYCLES  = OFF_AWAKE_CYC
) (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    // link pins
    input wire logic       hw_reset_line_n,
    input wire logic       chip_select_line_n,
    input wire logic       io_supply_rail,
    input wire logic       analog_supply_rail,
    input wire logic       cmd_valid,
    input wire logic [1:0] cmd_code
);
    logic [CNT_W-1:0] low_cnt_reg;
    logic [CNT_W-1:0] high_cnt_reg;
    logic             awake_reg;
    // cycles low and high, panel mode as commanded
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            low_cnt_reg  <= '0;
            high_cnt_reg <= '0;
            awake_reg    <= 1'b0;
        end else begin
            low_cnt_reg  <= hw_reset_line_n ? '0 : low_cnt_reg + 1'b1;
            high_cnt_reg <= hw_reset_line_n ? high_cnt_reg + 1'b1 : '0;
            if (!io_supply_rail)
                awake_reg <= 1'b0;
            else if (cmd_valid && cmd_code == CMD_LEAVE_SLEEP)
                awake_reg <= 1'b1;
            else if (cmd_valid && cmd_code == CMD_ENTER_SLEEP)
                awake_reg <= 1'b0;
        end
    end
    sequence s_release;
        $rose(hw_reset_line_n);
    endsequence
    sequence s_doze_entry;
        $fell(hw_reset_line_n) && io_supply_rail ##0 !awake_reg;
    endsequence
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_cs_held_low: assert property (chip_select_line_n == 1'b0)
        else $error("chip select not low");
    a_pulse_long_enough: assert property (s_release |-> low_cnt_reg >= ACCEPT_CYC)
        else $error("reset pulse too short");
    a_release_powered: assert property (s_release |-> io_supply_rail && analog_supply_rail)
        else $error("reset released unpowered");
    a_cmd_outside_reset: assert property (cmd_valid |-> hw_reset_line_n)
        else $error("command during reset");
    a_cmd_wait_held: assert property (cmd_valid |-> high_cnt_reg >= CMD_CYCLES - 1)
        else $error("command too early");
    a_wake_wait_held: assert property (cmd_valid && cmd_code == CMD_LEAVE_SLEEP |-> high_cnt_reg >= WAKE_CYCLES - 1)
        else $error("leave sleep too early");
    a_off_in_reset: assert property ($fell(io_supply_rail) |-> !hw_reset_line_n)
        else $error("supply off outside reset");
    a_off_awake_wait: assert property ($fell(io_supply_rail) && awake_reg |-> low_cnt_reg >= OFF_CYCLES - 1)
        else $error("awake supply off too soon");
    a_off_doze_fast: assert property (s_doze_entry |-> ##[1:2] !io_supply_rail)
        else $error("dozing supply off late");
endmodule

// ===== tb_top.sv
// self-checking bench: host and driver joined, plus a bench-driven driver
// assumes shortened waits from the localparams below
`timescale 1ns/1ns
module tb_top;
    import rst_seq_pkg::*;
    // shortened waits; host command wait covers filter release plus reload
    localparam int T_CMD    = 80;
    localparam int T_WAKE   = 120;
    localparam int T_OFF    = 150;
    localparam int T_RELOAD = 20;
    localparam int T_BLANK  = 40;
    logic       clk_sys;
    logic       sys_rst;
    logic [3:0] reqs;
    logic       busy;
    logic       host_awake;
    logic [4:0] st1;
    logic [4:0] st2;
    int         num_errors = 0;
    int         tests_run  = 0;
    int         seed       = 32'h83d8;
    int         cyc_cnt    = 0;
    int         rnd;
    int         m_awake;
    int         m_loaded;
    int         m_rst;
    int         k;
    int         cmd_q[$] = '{3, 1, 3, 2, 1};
    logic       seen_rst = 1'b0;
    panel_link_if link();
    panel_link_if link2();
    panel_host #(.CMD_CYCLES(T_CMD), .WAKE_CYCLES(T_WAKE), .OFF_CYCLES(T_OFF)) panel_host_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .req_power_up(reqs[0]), .req_wake(reqs[1]),
        .req_sleep(reqs[2]), .req_power_down(reqs[3]), .busy(busy), .host_awake(host_awake), .link(link));
    panel_driver #(.RELOAD_CYCLES(T_RELOAD), .BLANK_CYCLES(T_BLANK)) panel_driver_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .link(link), .reset_active(st1[4]), .display_on(st1[3]),
        .awake(st1[2]), .settings_loaded(st1[1]), .cmd_accepted(st1[0]));
    panel_driver #(.RELOAD_CYCLES(T_RELOAD), .BLANK_CYCLES(T_BLANK)) panel_driver_i2 (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .link(link2), .reset_active(st2[4]), .display_on(st2[3]),
        .awake(st2[2]), .settings_loaded(st2[1]), .cmd_accepted(st2[0]));
    panel_link_properties #(.CMD_CYCLES(T_CMD), .WAKE_CYCLES(T_WAKE), .OFF_CYCLES(T_OFF)) panel_link_properties_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .hw_reset_line_n(link.hw_reset_line_n),
        .chip_select_line_n(link.chip_select_line_n), .io_supply_rail(link.io_supply_rail),
        .analog_supply_rail(link.analog_supply_rail), .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc_cnt++;
        if (st1[4] === 1'b1) seen_rst <= 1'b1;
        if (cyc_cnt == 8000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic req(input int idx, input bit ready);
        int n;
        reqs[idx] = 1'b1;
        n = 0;
        do begin cyc(1); n++; end while (busy !== 1'b1 && host_awake !== 1'(idx == 1) && n < 200);
        reqs[idx] = 1'b0;
        cyc(2);
        n = 0;
        while (ready && busy !== 1'b0 && n < 3000) begin cyc(1); n++; end
    endtask
    task automatic low2(input int n);
        link2.hw_reset_line_n = 1'b0;
        repeat (n) begin
            rnd = $random(seed);
            link2.chip_select_line_n = rnd[0];
            cyc(1);
        end
        link2.chip_select_line_n = 1'b0;
        link2.hw_reset_line_n = 1'b1;
    endtask
    // model: accepted only when loaded and out of reset
    task automatic cmd2(input int code);
        logic acc;
        acc = (m_loaded == 1 && m_rst == 0);
        link2.cmd_code = code[1:0];
        link2.cmd_valid = 1'b1;
        cyc(1);
        link2.cmd_valid = 1'b0;
        if (acc && code == 1) m_awake = 1;
        if (acc && code == 2) m_awake = 0;
        check(st2, {m_rst[0], m_awake[0], m_awake[0], m_loaded[0], acc});
        cyc(1);
    endtask
    task automatic wait_loaded();
        k = 0;
        while (st2[1] !== 1'b1 && k < 200) begin cyc(1); k++; end
        m_rst = 0;
        m_loaded = 1;
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        sys_rst = 1'b1;
        reqs = 4'h0;
        link2.hw_reset_line_n = 1'b0;
        link2.chip_select_line_n = 1'b0;
        link2.io_supply_rail = 1'b1;
        link2.analog_supply_rail = 1'b1;
        link2.cmd_valid = 1'b0;
        link2.cmd_code = 2'h0;
        m_awake = 0;
        m_loaded = 0;
        m_rst = 1;
        cyc(20);
        sys_rst = 1'b0;
        check({busy, link.hw_reset_line_n, link.io_supply_rail, 2'b00}, 5'h10);
        cyc(100);
        check(st2, 5'h10);
        cmd2(1);
        rnd = $random(seed);
        link2.hw_reset_line_n = 1'b1;
        cyc(1 + {rnd[31:1]} % 50);
        check(st2, 5'h10);
        low2(10);
        wait_loaded();
        check({st2, 27'(k <= 51 + 20 + 2)}, {5'h02, 27'd1});
        repeat (6) begin
            rnd = $random(seed);
            low2(1 + {rnd[31:1]} % 49);
            cyc(3);
            check(st2, 5'h02);
        end
        foreach (cmd_q[i]) cmd2(cmd_q[i]);
        low2(95);
        check(st2, 5'h14);
        m_awake = 0;
        cyc(150);
        check(st2, 5'h02);
        req(0, 1);
        check({seen_rst, link.hw_reset_line_n, link.io_supply_rail, link.analog_supply_rail, 1'b0}, 5'h1e);
        check(st1, 5'h02);
        req(1, 1);
        check({st1[4:1], host_awake}, 5'h0f);
        req(2, 1);
        check({st1[4:1], host_awake}, 5'h02);
        req(1, 1);
        req(3, 0);
        cyc(100);
        check({st1, link.io_supply_rail}, 6'h29);
        cyc(60);
        check({st1, link.io_supply_rail}, 6'h20);
        req(0, 1);
        req(3, 0);
        cyc(5);
        check({link.io_supply_rail, link.analog_supply_rail}, 5'h00);
        summarize();
    end
endmodule
